// ### src/uhc_consts.svh
// constants for usb host command and event status block
`ifndef UHC_CONSTS_SVH
`define UHC_CONSTS_SVH

`define UHC_ADDR_W      8
`define UHC_OFF_CMD     8'h08
`define UHC_OFF_STS     8'h0c
`define UHC_OFF_IEN     8'h10
`define UHC_OFF_IDIS    8'h14

`define UHC_B_HCR       0
`define UHC_B_CLF       1
`define UHC_B_OCR       3
`define UHC_B_SOC       16
`define UHC_B_SO        0
`define UHC_B_WDH       1
`define UHC_B_SF        2
`define UHC_B_RD        3
`define UHC_B_UE        4
`define UHC_B_FNO       5
`define UHC_B_ROOT_HUB_CHANGED      6
`define UHC_B_OC        30
`define UHC_B_MIE       31

`define UHC_CLK_NS      4
`define UHC_RST_NS      10000
`define UHC_RST_CYC     (`UHC_RST_NS / `UHC_CLK_NS)
`define UHC_CNT_W       12

`endif

// ### src/uhc_pkg.sv
// types for usb host command and event status block
package uhc_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } uhc_bus_t;

  typedef struct packed {
    logic ctl_start;
    logic td_found;
    logic own_done;
    logic rh_change;
    logic frame_upd;
    logic frame_msb;
    logic sys_err;
    logic sof;
    logic done_wr;
    logic overrun;
  } uhc_hc_evt_t;

  typedef struct packed {
    logic oc;
    logic root_hub_changed;
    logic frame_number_overflow;
    logic ue;
    logic rd;
    logic sf;
    logic done_head_written;
    logic so;
  } uhc_flags_t;

  typedef enum logic {
    UHC_RUN = 1'b0,
    UHC_RST = 1'b1
  } uhc_phase_t;

  typedef struct packed {
    uhc_phase_t  phase;
    logic [11:0] cnt;
    logic        control_list_filled;
    logic        ocr;
    logic [1:0]  soc;
    uhc_flags_t  sts;
    uhc_flags_t  en;
    logic        mie;
    logic [2:0]  sync;
    logic        res_lvl;
    logic        msb_last;
    logic [31:0] rdata;
    logic        irq;
    logic        smi;
    logic        sof_tok;
    logic        go;
  } uhc_state_t;

endpackage

// ### src/uhc_cmd_irq_status.sv
// command register, event status and interrupt request logic
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "uhc_consts.svh"

module uhc_cmd_irq_status
  import uhc_pkg::*;
#(
  parameter bit HAS_SMI = 1'b1
) (
  input  wire logic        clk_i,            // system clock
  input  wire logic        rst_i,            // sync reset, high
  input  wire uhc_bus_t    bus_i,            // register port
  input  wire uhc_hc_evt_t evt_i,            // engine events
  input  wire logic        resume_pin_i,     // bus resume level
  input  wire logic        resuming_state_i, // sw resume state
  output logic [31:0]      rdata_o,          // read data
  output logic             irq_o,            // interrupt request
  output logic             smi_o,            // management irq
  output logic             sof_token_o,      // emit sof token
  output logic             ctl_go_o,         // start control list
  output logic             halt_o,           // stop on sys error
  output logic             done_hold_o,      // block done write
  output logic             soft_reset_o      // suspend, no bus
);

  uhc_state_t s;
  uhc_state_t next_s;
  logic       wcmd;
  logic       wsts;
  logic       wen;
  logic       wdis;

  function automatic uhc_flags_t unpack(input logic [31:0] w);
    uhc_flags_t f;
    f.oc   = w[`UHC_B_OC];
    f.root_hub_changed = w[`UHC_B_ROOT_HUB_CHANGED];
    f.frame_number_overflow  = w[`UHC_B_FNO];
    f.ue   = w[`UHC_B_UE];
    f.rd   = w[`UHC_B_RD];
    f.sf   = w[`UHC_B_SF];
    f.done_head_written  = w[`UHC_B_WDH];
    f.so   = w[`UHC_B_SO];
    return f;
  endfunction

  function automatic logic [31:0] pack(input uhc_flags_t f);
    logic [31:0] w;
    w = 32'h0;
    w[`UHC_B_OC]   = f.oc;
    w[`UHC_B_ROOT_HUB_CHANGED] = f.root_hub_changed;
    w[`UHC_B_FNO]  = f.frame_number_overflow;
    w[`UHC_B_UE]   = f.ue;
    w[`UHC_B_RD]   = f.rd;
    w[`UHC_B_SF]   = f.sf;
    w[`UHC_B_WDH]  = f.done_head_written;
    w[`UHC_B_SO]   = f.so;
    return w;
  endfunction

  assign wcmd = bus_i.wr && (bus_i.addr == `UHC_OFF_CMD);
  assign wsts = bus_i.wr && (bus_i.addr == `UHC_OFF_STS);
  assign wen  = bus_i.wr && (bus_i.addr == `UHC_OFF_IEN);
  assign wdis = bus_i.wr && (bus_i.addr == `UHC_OFF_IDIS);

  always_comb begin
    logic [31:0] rv;
    uhc_flags_t  irq_src;
    rv = 32'h0;
    irq_src = '0;
    next_s = s;
    next_s.rdata   = 32'h0;
    next_s.go      = 1'b0;
    next_s.sof_tok = 1'b0;
    // resume pin filter, change taken when stages 2 and 3 agree
    next_s.sync = {s.sync[1:0], resume_pin_i};
    if (s.sync[1] == s.sync[2]) begin
      next_s.res_lvl = s.sync[2];
    end
    unique case (s.phase)
      UHC_RUN: begin
        if (wcmd && bus_i.wdata[`UHC_B_HCR]) begin
          // no root hub reset output exists
          next_s.phase = UHC_RST;
          next_s.cnt   = '0;
          next_s.control_list_filled   = 1'b0;
          next_s.ocr   = 1'b0;
          next_s.soc   = '0;
          next_s.sts   = '0;
          next_s.en    = '0;
          next_s.mie   = 1'b0;
        end else begin
          // list start consumes the filled flag
          if (evt_i.ctl_start && s.control_list_filled && !s.sts.ue) begin
            next_s.go  = 1'b1;
            next_s.control_list_filled = 1'b0;
          end
          // empty flag: no start
          if (evt_i.td_found) begin
            next_s.control_list_filled = 1'b1;
          end
          // changeover done first, so a new request in the same cycle stays
          if (evt_i.own_done) begin
            next_s.ocr = 1'b0;
          end
          if (wcmd) begin
            // write-to-set, zeros leave bits alone
            if (bus_i.wdata[`UHC_B_CLF]) begin
              next_s.control_list_filled = 1'b1;
            end
            if (bus_i.wdata[`UHC_B_OCR]) begin
              next_s.ocr = 1'b1;
            end
          end
          // software clear first so that a same-cycle set wins
          if (wsts) begin
            next_s.sts = s.sts & ~unpack(bus_i.wdata);
          end
          if (wcmd && bus_i.wdata[`UHC_B_OCR]) begin
            next_s.sts.oc = 1'b1;
          end
          if (evt_i.rh_change) begin
            next_s.sts.root_hub_changed = 1'b1;
          end
          if (evt_i.frame_upd) begin
            next_s.msb_last = evt_i.frame_msb;
            if (evt_i.frame_msb != s.msb_last) begin
              next_s.sts.frame_number_overflow = 1'b1;
            end
          end
          if (evt_i.sys_err) begin
            next_s.sts.ue = 1'b1;
          end
          if (next_s.res_lvl && !s.res_lvl && !resuming_state_i) begin
            next_s.sts.rd = 1'b1;
          end
          if (evt_i.sof && !s.sts.ue) begin
            next_s.sts.sf  = 1'b1;
            next_s.sof_tok = 1'b1;
          end
          if (evt_i.done_wr) begin
            next_s.sts.done_head_written = 1'b1;
          end
          if (evt_i.overrun) begin
            next_s.sts.so = 1'b1;
            next_s.soc    = 2'(s.soc + 2'h1);
          end
          if (wen) begin
            next_s.en  = s.en | unpack(bus_i.wdata);
            next_s.mie = s.mie | bus_i.wdata[`UHC_B_MIE];
          end
          if (wdis) begin
            next_s.en  = s.en & ~unpack(bus_i.wdata);
            next_s.mie = s.mie & ~bus_i.wdata[`UHC_B_MIE];
          end
        end
      end
      UHC_RST: begin
        // held in suspend with all host bus traffic blocked
        next_s.cnt = 12'(s.cnt + 12'h1);
        if (s.cnt == 12'(`UHC_RST_CYC - 1)) begin
          next_s.phase = UHC_RUN;
          next_s.cnt   = '0;
        end
      end
    endcase
    if (!HAS_SMI) begin
      next_s.sts.oc = 1'b0;
    end
    irq_src    = next_s.sts & next_s.en;
    irq_src.oc = 1'b0;
    next_s.irq = next_s.mie && (|irq_src);
    next_s.smi = HAS_SMI && next_s.mie && next_s.sts.oc
                 && next_s.en.oc;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `UHC_OFF_CMD: begin
          rv[`UHC_B_SOC +: 2] = s.soc;
          rv[`UHC_B_OCR]      = s.ocr;
          rv[`UHC_B_CLF]      = s.control_list_filled;
          rv[`UHC_B_HCR]      = (s.phase == UHC_RST);
        end
        `UHC_OFF_STS: begin
          rv = pack(s.sts);
        end
        `UHC_OFF_IEN, `UHC_OFF_IDIS: begin
          rv = pack(s.en);
          rv[`UHC_B_MIE] = s.mie;
        end
        default: begin
          rv = 32'h0;
        end
      endcase
    end
    next_s.rdata = rv;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o      = s.rdata;
  assign irq_o        = s.irq;
  assign smi_o        = s.smi;
  assign sof_token_o  = s.sof_tok;
  assign ctl_go_o     = s.go;
  assign halt_o       = s.sts.ue;
  assign done_hold_o  = s.sts.done_head_written;
  assign soft_reset_o = (s.phase == UHC_RST);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic run;
  assign run = (s.phase == UHC_RUN) && !wcmd;

  property p_go_empty;
    run && evt_i.ctl_start && !s.control_list_filled |=> !ctl_go_o;
  endproperty
  a_go_empty: assert property (p_go_empty)
    else $error("control list started while empty");

  property p_go_start;
    run && evt_i.ctl_start && s.control_list_filled && !s.sts.ue && !evt_i.td_found
      |=> ctl_go_o && !s.control_list_filled;
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("control list start did not consume flag");

  property p_td_found;
    run && evt_i.td_found |=> s.control_list_filled;
  endproperty
  a_td_found: assert property (p_td_found)
    else $error("found descriptor did not refill flag");

  property p_rst_enter;
    wcmd && bus_i.wdata[`UHC_B_HCR] && !soft_reset_o
      |=> soft_reset_o && !s.control_list_filled && s.sts == '0;
  endproperty
  a_rst_enter: assert property (p_rst_enter)
    else $error("soft reset not entered");

  property p_rst_done;
    soft_reset_o |-> s.cnt < 12'(`UHC_RST_CYC);
  endproperty
  a_rst_done: assert property (p_rst_done)
    else $error("soft reset did not complete in time");

  property p_rst_step;
    soft_reset_o |=> !soft_reset_o || s.cnt == 12'($past(s.cnt) + 12'h1);
  endproperty
  a_rst_step: assert property (p_rst_step)
    else $error("soft reset counter stalled");

  property p_rst_quiet;
    soft_reset_o |-> !ctl_go_o && !sof_token_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("list or frame activity during soft reset");

  property p_clf_write;
    (s.phase == UHC_RUN) && wcmd && bus_i.wdata[`UHC_B_CLF]
      && !bus_i.wdata[`UHC_B_HCR] |=> s.control_list_filled;
  endproperty
  a_clf_write: assert property (p_clf_write)
    else $error("written one did not set list flag");

  property p_oc_set;
    (s.phase == UHC_RUN) && wcmd && bus_i.wdata[`UHC_B_OCR]
      && !bus_i.wdata[`UHC_B_HCR] |=> s.sts.oc == HAS_SMI;
  endproperty
  a_oc_set: assert property (p_oc_set)
    else $error("ownership flag wrong after request");

  property p_smi;
    run && s.mie && s.sts.oc && s.en.oc && !wsts && !wdis |=> smi_o;
  endproperty
  a_smi: assert property (p_smi)
    else $error("unmasked ownership change gave no smi");

  property p_irq_off;
    run && !s.mie && !wen |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without master enable");

  property p_root_hub_changed;
    run && evt_i.rh_change |=> s.sts.root_hub_changed;
  endproperty
  a_root_hub_changed: assert property (p_root_hub_changed)
    else $error("root hub change not flagged");

  property p_fno;
    run && evt_i.frame_upd && (evt_i.frame_msb != s.msb_last)
      |=> s.sts.frame_number_overflow;
  endproperty
  a_fno: assert property (p_fno)
    else $error("frame msb toggle not flagged");

  property p_fno_quiet;
    run && !s.sts.frame_number_overflow && !(evt_i.frame_upd && evt_i.frame_msb != s.msb_last)
      |=> !s.sts.frame_number_overflow;
  endproperty
  a_fno_quiet: assert property (p_fno_quiet)
    else $error("overflow flag set without msb toggle");

  property p_ue;
    run && evt_i.sys_err |=> halt_o;
  endproperty
  a_ue: assert property (p_ue)
    else $error("system error did not halt");

  property p_ue_quiet;
    halt_o |=> !sof_token_o && !ctl_go_o;
  endproperty
  a_ue_quiet: assert property (p_ue_quiet)
    else $error("frame or list activity while halted");

  property p_rd_set;
    run && !resuming_state_i && !s.res_lvl && s.sync[1] && s.sync[2]
      |=> s.sts.rd;
  endproperty
  a_rd_set: assert property (p_rd_set)
    else $error("resume onset not flagged");

  property p_wdh;
    run && evt_i.done_wr |=> done_hold_o;
  endproperty
  a_wdh: assert property (p_wdh)
    else $error("done head write not flagged");

  property p_rd_mask;
    bus_i.rd && (bus_i.addr == `UHC_OFF_STS)
      |=> (rdata_o & ~pack('1)) == 32'h0;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("reserved status bits read nonzero");

  property p_w1s;
    run && wcmd == 1'b0 && s.control_list_filled && !evt_i.ctl_start |=> s.control_list_filled;
  endproperty
  a_w1s: assert property (p_w1s)
    else $error("command bit lost without cause");

  property p_overrun;
    run && evt_i.overrun |=> s.sts.so && s.soc == 2'($past(s.soc) + 2'h1);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun flag or counter wrong");

  property p_sof;
    run && evt_i.sof && !s.sts.ue |=> sof_token_o && s.sts.sf;
  endproperty
  a_sof: assert property (p_sof)
    else $error("frame start flag and token not together");

  property p_set_wins;
    run && wsts && bus_i.wdata[`UHC_B_WDH] && evt_i.done_wr |=> s.sts.done_head_written;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("done flag set lost to clear");

  property p_sticky;
    run && !wsts && s.sts.ue |=> s.sts.ue;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error flag cleared by hardware");

  property p_irq;
    s.mie && |(s.sts & s.en & 8'h7f) && !wsts && !wdis && run
      |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag gave no interrupt");

  property p_resume_sw;
    resuming_state_i && run |=> $stable(s.sts.rd) || $past(wsts);
  endproperty
  a_resume_sw: assert property (p_resume_sw)
    else $error("resume flag set by software resume");

  c_go: cover property (ctl_go_o);
  c_rst: cover property ($fell(soft_reset_o));
  c_irq: cover property ($rose(irq_o));
  c_smi: cover property ($rose(smi_o));
  c_rd: cover property ($rose(s.sts.rd));

endmodule

// ### test/uhc_cmd_irq_status_bench.sv
// self-checking bench for the command and event status block
`timescale 1ns/100ps
`include "uhc_consts.svh"

module uhc_cmd_irq_status_bench
  import uhc_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  uhc_bus_t    bus;
  uhc_hc_evt_t evt;
  logic        res_pin;
  logic        res_st;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic        smi_o;
  logic        sof_token_o;
  logic        ctl_go_o;
  logic        halt_o;
  logic        done_hold_o;
  logic        soft_reset_o;
  int          n_mismatch;
  int          check_count;
  int          cyc;
  int          t0;
  logic        go_s;
  logic        tok_s;
  // event bits beside expected status word
  logic [41:0] tab [9];

  uhc_cmd_irq_status u_uhc_cmd_irq_status (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .bus_i            (bus),
    .evt_i            (evt),
    .resume_pin_i     (res_pin),
    .resuming_state_i (res_st),
    .rdata_o          (rdata_o),
    .irq_o            (irq_o),
    .smi_o            (smi_o),
    .sof_token_o      (sof_token_o),
    .ctl_go_o         (ctl_go_o),
    .halt_o           (halt_o),
    .done_hold_o      (done_hold_o),
    .soft_reset_o     (soft_reset_o)
  );

  always #2 clk_i = ~clk_i;

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1;
    chk(rdata_o, e);
  endtask

  // one-cycle event, outputs captured after it lands
  task automatic pulse(input logic [9:0] e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    #1;
    go_s = ctl_go_o;
    tok_s = sof_token_o;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    bus = '0;
    evt = '0;
    res_pin = 1'b0;
    res_st = 1'b0;
    tab = '{{10'h040, 32'h40}, {10'h008, 32'h10}, {10'h004, 32'h04},
            {10'h002, 32'h02}, {10'h001, 32'h01}, {10'h020, 32'h00},
            {10'h030, 32'h20}, {10'h030, 32'h00}, {10'h020, 32'h20}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      pulse(tab[i][41:32]);
      chk({tok_s, halt_o, done_hold_o}, {tab[i][2], tab[i][4], tab[i][1]});
      rd(`UHC_OFF_STS, tab[i][31:0]);
      if (tab[i][4]) begin
        wr(`UHC_OFF_CMD, 32'h1);
        repeat (2600) @(posedge clk_i);
      end
      wr(`UHC_OFF_STS, 32'hffff_ffff);
      rd(`UHC_OFF_STS, 32'h0);
    end
    rd(`UHC_OFF_CMD, 32'h0001_0000);
    rd(`UHC_OFF_IEN, 32'h0);
    wr(`UHC_OFF_CMD, 32'hfffc_fff6);
    rd(`UHC_OFF_CMD, 32'h0001_0002);
    wr(`UHC_OFF_CMD, 32'h0);
    rd(`UHC_OFF_CMD, 32'h0001_0002);
    wr(`UHC_OFF_IEN, 32'h3fff_ff80);
    rd(`UHC_OFF_IEN, 32'h0);
    // control list start, empty start, refill by descriptor
    pulse(10'h200);
    chk(go_s, 1'b1);
    rd(`UHC_OFF_CMD, 32'h0001_0000);
    pulse(10'h200);
    chk(go_s, 1'b0);
    wr(`UHC_OFF_CMD, 32'h2);
    pulse(10'h300);
    chk(go_s, 1'b1);
    rd(`UHC_OFF_CMD, 32'h0001_0002);
    // overrun count wraps after three
    repeat (2) pulse(10'h001);
    rd(`UHC_OFF_CMD, 32'h0003_0002);
    pulse(10'h001);
    rd(`UHC_OFF_CMD, 32'h0000_0002);
    // interrupt needs flag, enable and master
    pulse(10'h004);
    wr(`UHC_OFF_STS, 32'h0);
    rd(`UHC_OFF_STS, 32'h05);
    wr(`UHC_OFF_IEN, 32'h4);
    rd(`UHC_OFF_IEN, 32'h4);
    chk(irq_o, 1'b0);
    wr(`UHC_OFF_IEN, 32'h8000_0000);
    rd(`UHC_OFF_IEN, 32'h8000_0004);
    chk(irq_o, 1'b1);
    wr(`UHC_OFF_IDIS, 32'h4);
    rd(`UHC_OFF_IEN, 32'h8000_0000);
    chk(irq_o, 1'b0);
    wr(`UHC_OFF_STS, 32'h05);
    // resume in software resume state must stay quiet
    @(posedge clk_i);
    res_st <= 1'b1;
    res_pin <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(`UHC_OFF_STS, 32'h0);
    @(posedge clk_i);
    res_pin <= 1'b0;
    repeat (10) @(posedge clk_i);
    res_st <= 1'b0;
    res_pin <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(`UHC_OFF_STS, 32'h08);
    @(posedge clk_i);
    res_pin <= 1'b0;
    wr(`UHC_OFF_STS, 32'h08);
    // ownership request gives smi, not irq
    wr(`UHC_OFF_CMD, 32'h8);
    rd(`UHC_OFF_STS, 32'h4000_0000);
    wr(`UHC_OFF_IEN, 32'h4000_0000);
    rd(`UHC_OFF_IEN, 32'hc000_0000);
    chk({smi_o, irq_o}, 2'b10);
    // soft reset: self-clearing, ignores writes, clears state
    wr(`UHC_OFF_CMD, 32'h1);
    #1;
    t0 = cyc;
    chk(soft_reset_o, 1'b1);
    rd(`UHC_OFF_CMD, 32'h1);
    wr(`UHC_OFF_IEN, 32'h8000_0004);
    while (soft_reset_o === 1'b1 && cyc - t0 < 3000) begin
      @(posedge clk_i);
      #1;
    end
    chk(cyc - t0 <= 2501, 1'b1);
    rd(`UHC_OFF_CMD, 32'h0);
    rd(`UHC_OFF_IEN, 32'h0);
    chk({smi_o, irq_o, soft_reset_o}, 3'b0);
    // synchronous reset mid-run drops pending state
    wr(`UHC_OFF_CMD, 32'h2);
    pulse(10'h041);
    rd(`UHC_OFF_STS, 32'h41);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`UHC_OFF_STS, 32'h0);
    rd(`UHC_OFF_CMD, 32'h0);
    chk({irq_o, smi_o, halt_o, done_hold_o}, 4'h0);
    final_report();
  end
endmodule
